// file: core/exhf_osc_ctrl.sv
// Control register and run logic for the external high-frequency oscillator.
// Assumes requests, sleep state and oscillator edge pulses are synchronous.
//
// What this block does
// - With run-in-standby clear, the oscillator runs only while someone requests it.
// - With run-in-standby set and enabled, it runs in active, idle and standby.
// - Once started, the clock reaches a requester two oscillator cycles after its request.
// - In crystal mode the start-up waits 256, 1K or 4K cycles; code 3 is reserved.
// - Start-up count and source select are locked while enabled or stable.
// - The frequency range field decodes to 8, 16, 24 or 32 MHz maximum.
// - Source select 0 means a crystal on both pins, 1 an external clock on pin one.
// - The enable bit lets the oscillator run on request or with run-in-standby set, and takes its pins from port logic.
// - The low-frequency crystal enable bit takes its pins from port logic.
`timescale 1ns/1ps
`default_nettype none
module exhf_osc_ctrl
  import exhf_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       reset_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic       clk_request_in,
  input  wire logic       sleep_deep_in,
  input  wire logic       osc_edge_in,
  output logic            osc_run_out,
  output logic            clk_valid_out,
  output logic            ext_hf_stable_flag_out,
  output exhf_pins_s      pins_out
);
  typedef struct packed {
    exhf_ctrl_s ctrl;
    logic       lf_en;
    logic       stable;
    logic       run;
    logic [1:0] deliver_cnt;
    logic       valid;
    logic [7:0] rdata;
    exhf_pins_s pins;
  } exhf_state_s;

  exhf_state_s state_reg;
  exhf_state_s state_next;
  logic        startup_done;
  logic [12:0] startup_target;
  logic        run_cmd;
  logic [7:0]  ctrl_bits;
  logic [7:0]  wr_val;
  logic        locked;

  always_comb begin
    unique case (state_reg.ctrl.startup_count_select)
      EXHF_SUT_256: startup_target = EXHF_CYC_256;
      EXHF_SUT_1K:  startup_target = EXHF_CYC_1K;
      EXHF_SUT_4K:  startup_target = EXHF_CYC_4K;
      // Reserved code behaves as the longest wait, the safe choice
      default:      startup_target = EXHF_CYC_4K;
    endcase
  end

  exhf_startup_counter u_startup (
    .sys_clk_in  (sys_clk_in),
    .reset_in    (reset_in),
    .run_in      (state_reg.run && !state_reg.ctrl.source_select),
    .osc_edge_in (osc_edge_in),
    .target_in   (startup_target),
    .done_out    (startup_done)
  );

  always_comb begin
    ctrl_bits = {state_reg.ctrl.run_in_standby, 1'b0,
                 state_reg.ctrl.startup_count_select, state_reg.ctrl.freq_range_select,
                 state_reg.ctrl.source_select, state_reg.ctrl.enable};
    locked = state_reg.ctrl.enable || state_reg.stable;
    wr_val = wdata_in & EXHF_CTRL_MASK;
    if (locked) begin
      wr_val = (wr_val & ~EXHF_LOCK_MASK) | (ctrl_bits & EXHF_LOCK_MASK);
    end
  end

  always_comb begin
    state_next = state_reg;
    if (wr_in && addr_in == EXHF_CTRL_ADDR) begin
      state_next.ctrl.run_in_standby       = wr_val[EXHF_RUNSTBY_BIT];
      state_next.ctrl.startup_count_select = wr_val[EXHF_SUT_LSB +: 2];
      state_next.ctrl.freq_range_select    = wr_val[EXHF_FRQ_LSB +: 2];
      state_next.ctrl.source_select        = wr_val[EXHF_SRC_BIT];
      state_next.ctrl.enable               = wr_val[EXHF_EN_BIT];
    end
    if (wr_in && addr_in == EXHF_LF_ADDR) begin
      state_next.lf_en = wdata_in[0];
    end

    run_cmd = state_reg.ctrl.enable && clk_request_in;
    if (state_reg.ctrl.enable && state_reg.ctrl.run_in_standby && !sleep_deep_in) begin
      run_cmd = 1'b1;
    end
    state_next.run = run_cmd;

    if (!state_reg.ctrl.enable) begin
      state_next.stable = 1'b0;
    end else if (state_reg.run && (state_reg.ctrl.source_select || startup_done)) begin
      state_next.stable = 1'b1;
    end

    if (!(clk_request_in && state_reg.run && state_reg.stable)) begin
      state_next.deliver_cnt = 2'h0;
      state_next.valid       = 1'b0;
    end else if (state_reg.deliver_cnt != EXHF_DELIVER_CYC) begin
      if (osc_edge_in) begin
        state_next.deliver_cnt = state_reg.deliver_cnt + 2'h1;
        state_next.valid = (state_reg.deliver_cnt + 2'h1) == EXHF_DELIVER_CYC;
      end
    end

    state_next.pins.osc_en        = run_cmd;
    state_next.pins.crystal_drive = run_cmd && !state_reg.ctrl.source_select;
    state_next.pins.pin_one_owned = state_reg.ctrl.enable;
    state_next.pins.pin_two_owned = state_reg.ctrl.enable && !state_reg.ctrl.source_select;
    state_next.pins.lf_en         = state_reg.lf_en;
    unique case (state_reg.ctrl.freq_range_select)
      2'h0: state_next.pins.max_mhz = EXHF_MHZ_8;
      2'h1: state_next.pins.max_mhz = EXHF_MHZ_16;
      2'h2: state_next.pins.max_mhz = EXHF_MHZ_24;
      2'h3: state_next.pins.max_mhz = EXHF_MHZ_32;
    endcase

    state_next.rdata = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        EXHF_CTRL_ADDR:   state_next.rdata = ctrl_bits;
        EXHF_STATUS_ADDR: state_next.rdata = {6'h00, state_reg.valid, state_reg.stable};
        EXHF_LF_ADDR:     state_next.rdata = {7'h00, state_reg.lf_en};
        default:          state_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata_out              = state_reg.rdata;
  assign osc_run_out            = state_reg.run;
  assign clk_valid_out          = state_reg.valid;
  assign ext_hf_stable_flag_out = state_reg.stable;
  assign pins_out               = state_reg.pins;
endmodule // exhf_osc_ctrl
`default_nettype wire

// file: core/exhf_pkg.sv
// Package for the external high-frequency oscillator control block.
// Assumes a single 10 MHz system clock and the plain register port.
package exhf_pkg;
  localparam logic [7:0] EXHF_CTRL_ADDR    = 8'h20;
  localparam logic [7:0] EXHF_STATUS_ADDR  = 8'h21;
  localparam logic [7:0] EXHF_LF_ADDR      = 8'h22;
  localparam logic [7:0] EXHF_CTRL_RESET   = 8'h00;
  localparam int         EXHF_RUNSTBY_BIT  = 7;
  localparam int         EXHF_SUT_LSB      = 4;
  localparam int         EXHF_FRQ_LSB      = 2;
  localparam int         EXHF_SRC_BIT      = 1;
  localparam int         EXHF_EN_BIT       = 0;
  localparam logic [7:0] EXHF_CTRL_MASK    = 8'hBF;
  localparam logic [7:0] EXHF_LOCK_MASK    = 8'h32;
  localparam logic [1:0] EXHF_SUT_256      = 2'h0;
  localparam logic [1:0] EXHF_SUT_1K       = 2'h1;
  localparam logic [1:0] EXHF_SUT_4K       = 2'h2;
  localparam logic [12:0] EXHF_CYC_256     = 13'h0100;
  localparam logic [12:0] EXHF_CYC_1K      = 13'h0400;
  localparam logic [12:0] EXHF_CYC_4K      = 13'h1000;
  localparam logic [1:0] EXHF_DELIVER_CYC  = 2'h2;
  localparam logic [5:0] EXHF_MHZ_8        = 6'h08;
  localparam logic [5:0] EXHF_MHZ_16       = 6'h10;
  localparam logic [5:0] EXHF_MHZ_24       = 6'h18;
  localparam logic [5:0] EXHF_MHZ_32       = 6'h20;

  typedef struct packed {
    logic       run_in_standby;
    logic [1:0] startup_count_select;
    logic [1:0] freq_range_select;
    logic       source_select;
    logic       enable;
  } exhf_ctrl_s;

  typedef struct packed {
    logic       osc_en;
    logic       crystal_drive;
    logic       pin_one_owned;
    logic       pin_two_owned;
    logic       lf_en;
    logic [5:0] max_mhz;
  } exhf_pins_s;
endpackage : exhf_pkg

// file: core/exhf_startup_counter.sv
// Counts oscillator edges after enable until the start-up count is reached.
// Assumes osc_edge_in is a one-cycle pulse per oscillator cycle, synchronous.
`timescale 1ns/1ps
`default_nettype none
module exhf_startup_counter
  import exhf_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  input  wire logic        run_in,
  input  wire logic        osc_edge_in,
  input  wire logic [12:0] target_in,
  output logic             done_out
);
  typedef struct packed {
    logic [12:0] count;
    logic        done;
  } exhf_cnt_s;

  exhf_cnt_s state_reg;
  exhf_cnt_s state_next;

  always_comb begin
    state_next = state_reg;
    if (!run_in) begin
      state_next = '0;
    end else if (!state_reg.done && osc_edge_in) begin
      state_next.count = state_reg.count + 13'h0001;
      if (state_reg.count + 13'h0001 >= target_in) begin
        state_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign done_out = state_reg.done;
endmodule // exhf_startup_counter
`default_nettype wire

// file: sim/exhf_osc_ctrl_chk.sv
// Port assertions for the oscillator control block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module exhf_osc_ctrl_chk
  import exhf_pkg::*;
(
  input wire logic       sys_clk_in,
  input wire logic       reset_in,
  input wire logic [7:0] addr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       clk_request_in,
  input wire logic       osc_edge_in,
  input wire logic       osc_run_out,
  input wire logic       clk_valid_out,
  input wire logic       ext_hf_stable_flag_out,
  input wire exhf_pins_s pins_out
);
  logic [13:0] edge_cnt_reg;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // Never below the design's count, so a lower bound on it is safe
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || !pins_out.osc_en) edge_cnt_reg <= 14'h0000;
    else if (osc_edge_in && osc_run_out) edge_cnt_reg <= edge_cnt_reg + 14'h0001;
  end
  sequence s_rd_ctrl; rd_in && addr_in == EXHF_CTRL_ADDR; endsequence
  sequence s_crystal_source_up; $rose(ext_hf_stable_flag_out) && pins_out.crystal_drive; endsequence
  AST_RUN_EN: assert property (osc_run_out |-> pins_out.osc_en || $past(pins_out.osc_en))
    else $error("run without enable");
  // Stable may outlive a dropped request, but never the enable bit
  AST_STABLE_EN: assert property (ext_hf_stable_flag_out |-> pins_out.pin_one_owned)
    else $error("stable after disable");
  AST_VALID_REQ: assert property (clk_valid_out |-> $past(clk_request_in))
    else $error("clock given without request");
  AST_VALID_STB: assert property (clk_valid_out |-> $past(ext_hf_stable_flag_out))
    else $error("clock given before stable");
  // Pin one stays owned while enabled, pin two only in crystal mode, even when nobody requests the clock
  AST_PIN_TWO: assert property (pins_out.crystal_drive |->
    pins_out.pin_two_owned && pins_out.osc_en) else $error("pin two ownership wrong");
  AST_PIN_ONE: assert property (pins_out.osc_en |-> pins_out.pin_one_owned)
    else $error("pin one ownership wrong");
  AST_RD_BIT6: assert property (s_rd_ctrl |=> !rdata_out[6])
    else $error("unused bit reads one");
  AST_STARTUP: assert property (s_crystal_source_up |-> edge_cnt_reg >= 14'h00FF)
    else $error("stable before start-up count");
endmodule // exhf_osc_ctrl_chk
bind exhf_osc_ctrl exhf_osc_ctrl_chk u_chk (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
  .addr_in(addr_in), .rd_in(rd_in), .rdata_out(rdata_out), .clk_request_in(clk_request_in),
  .osc_edge_in(osc_edge_in), .osc_run_out(osc_run_out), .clk_valid_out(clk_valid_out),
  .ext_hf_stable_flag_out(ext_hf_stable_flag_out), .pins_out(pins_out));
`default_nettype wire

// file: sim/exhf_crystal_source_model.sv
// Crystal model: one edge pulse every DIV system cycles while running.
// Assumes run_in is the design's registered run level.
`timescale 1ns/1ps
`default_nettype none
module exhf_crystal_source_model #(parameter int DIV = 2) (
  input  wire logic sys_clk_in,
  input  wire logic run_in,
  output logic      edge_out
);
  int cnt = 0;
  initial edge_out = 1'b0;
  // A stopped crystal gives no edges at all
  // Plain always: the start value above comes from a second process
  always @(posedge sys_clk_in) begin
    cnt <= run_in ? (cnt + 1) % DIV : 0;
    edge_out <= run_in && cnt == DIV - 1;
  end
endmodule // exhf_crystal_source_model
`default_nettype wire

// file: sim/exhf_osc_ctrl_bench.sv
// Self-checking bench for the oscillator control block.
// Assumes the crystal model drives the edge input.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module exhf_osc_ctrl_bench;
  import exhf_pkg::*;
  logic       sys_clk = 1'b0, reset = 1'b1, w_en = 1'b0, r_en = 1'b0;
  logic       req = 1'b0, deep = 1'b0, edge_w, run, valid, stable;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  exhf_pins_s pins;
  int         error_cnt = 0, checks = 0;
  initial forever #50 sys_clk = ~sys_clk;
  exhf_osc_ctrl DUT (.sys_clk_in(sys_clk), .reset_in(reset), .addr_in(addr), .wdata_in(wdata),
    .wr_in(w_en), .rd_in(r_en), .rdata_out(rdata), .clk_request_in(req), .sleep_deep_in(deep),
    .osc_edge_in(edge_w), .osc_run_out(run), .clk_valid_out(valid),
    .ext_hf_stable_flag_out(stable), .pins_out(pins));
  exhf_crystal_source_model #(.DIV(2)) crystal_source (.sys_clk_in(sys_clk), .run_in(run), .edge_out(edge_w));
  task automatic wr(input logic [7:0] a, d);
    @(posedge sys_clk); addr <= a; wdata <= d; w_en <= 1'b1;
    @(posedge sys_clk); w_en <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, e);
    @(posedge sys_clk); addr <= a; r_en <= 1'b1;
    @(posedge sys_clk); r_en <= 1'b0;
    #1 `CHK("rdata", e, rdata);
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic t_lock;
    rdc(EXHF_CTRL_ADDR, EXHF_CTRL_RESET);
    wr(EXHF_CTRL_ADDR, 8'h11);
    wr(EXHF_CTRL_ADDR, 8'h2F);
    rdc(EXHF_CTRL_ADDR, 8'h1D);
    wr(EXHF_CTRL_ADDR, 8'h00);
    wr(EXHF_CTRL_ADDR, 8'h7E);
    rdc(EXHF_CTRL_ADDR, 8'h3E);
    rdc(8'h30, 8'h00);
  endtask
  task automatic t_freq;
    // dividing a fast crystal down is software's job, not exercised here
    for (int k = 0; k < 4; k++) begin
      wr(EXHF_CTRL_ADDR, {4'h0, 2'(k), 2'h0});
      wt(2);
      `CHK("max_mhz", 6'((k + 1) * 8), pins.max_mhz);
    end
  endtask
  task automatic t_start;
    int n;
    int cy;
    for (int c = 0; c < 4; c++) begin
      cy = c == 0 ? 256 : c == 1 ? 1024 : 4096;
      req <= 1'b1;
      wr(EXHF_CTRL_ADDR, {2'h0, 2'(c), 4'h1});
      n = 0;
      while (stable !== 1'b1 && n < 9000) begin wt(1); n++; end
      `CHK("startup", 1'b1, n >= 2 * cy - 4 && n <= 2 * cy + 8);
      `CHK("valid_early", 1'b0, valid);
      `CHK("pin_two", 1'b1, pins.pin_two_owned);
      `CHK("crystal_source_run", 2'h3, {pins.osc_en, pins.crystal_drive});
      wt(6);
      `CHK("valid", 1'b1, valid);
      rdc(EXHF_STATUS_ADDR, 8'h03);
      req <= 1'b0;
      wt(3);
      `CHK("run_idle", 1'b0, run);
      wr(EXHF_CTRL_ADDR, 8'h00);
      wt(2);
      `CHK("stable_off", 1'b0, stable);
    end
  endtask
  task automatic t_ext;
    req <= 1'b1;
    wr(EXHF_CTRL_ADDR, 8'h03);
    wt(4);
    `CHK("ext_stable", 1'b1, stable);
    `CHK("ext_pins", 3'b100, {pins.pin_one_owned, pins.pin_two_owned, pins.crystal_drive});
    req <= 1'b0;
    wr(EXHF_CTRL_ADDR, 8'h81);
    wt(3);
    `CHK("stby_run", 1'b1, run);
    deep <= 1'b1;
    wt(3);
    `CHK("deep_run", 1'b0, run);
    deep <= 1'b0;
    wr(EXHF_CTRL_ADDR, 8'h03);
    wt(3);
    `CHK("noreq_run", 1'b0, run);
    wr(EXHF_CTRL_ADDR, 8'h00);
  endtask
  task automatic t_lf;
    wr(EXHF_LF_ADDR, 8'h01);
    wt(2);
    `CHK("lf_en", 1'b1, pins.lf_en);
    rdc(EXHF_LF_ADDR, 8'h01);
    wr(EXHF_LF_ADDR, 8'h00);
    wt(2);
    `CHK("lf_off", 1'b0, pins.lf_en);
  endtask
  task automatic close_out;
    if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    wt(1);
    `CHK("pins_rst", '0, pins);
    t_lock;
    t_freq;
    t_start;
    t_ext;
    t_lf;
    close_out;
  end
  // Start-up runs take about 20k cycles
  initial begin
    repeat (40000) @(posedge sys_clk);
    error_cnt++;
    close_out;
  end
endmodule // exhf_osc_ctrl_bench
`default_nettype wire
